/* File: hw/crt_readout_regs.svh */
// Offsets, field positions and timing counts for the readout bus ports.
// Assumes a 200 MHz mclk; included by the package only; the design module reuses its macros.
`ifndef CRT_READOUT_REGS_SVH
`define CRT_READOUT_REGS_SVH

`define CTRL_NIBBLE 4'h5
`define LOAD_NIBBLE 4'h2
`define CTRL_RESET 8'h00
`define CB_ON 0
`define CB_ADDR_MODE 1
`define CB_A9 2
`define CB_MAX_SPAN 3
`define CB_A8 4
`define CB_LINES16 5
`define CB_COL40 6
`define CB_SPECTRUM 7
`define LB_SKIP 6
`define LB_BLANK 7
`define CLK_MHZ 200
`define GAP_US 140
`define GAP_CYC (`GAP_US * `CLK_MHZ)
`define RETRACE_NS 5900
`define RETRACE_CYC ((`RETRACE_NS * `CLK_MHZ) / 1000)
`define UNBLANK_US 5
`define UNBLANK_CYC (`UNBLANK_US * `CLK_MHZ)

`endif

/* File: hw/crt_readout_pkg.sv */
// Types shared by the readout port logic and its bench.
// Assumes crt_readout_regs.svh is on the include path.
package crt_readout_pkg;
`include "crt_readout_regs.svh"

   typedef struct packed {
      logic spectrum_en;
      logic col40;
      logic lines16;
      logic a8;
      logic max_span;
      logic a9;
      logic addr_mode;
      logic readout_on;
   } ctrl_t;

   typedef struct packed {
      logic blank;
      logic skip;
      logic [5:0] code;
   } char_t;

   typedef enum logic [2:0] {
      MK_IDLE = 3'b001,
      MK_RETRACE = 3'b010,
      MK_DRAW = 3'b100
   } marker_st_t;

   typedef struct packed {
      logic [2:0] strobe_sync;
      logic [11:0] bus_s1;
      logic [11:0] bus_s2;
      logic [3:0] nib_q;
      logic [7:0] data_q;
      logic [1:0] lined_sync;
      logic lined_q;
      ctrl_t ctrl;
      logic [7:0] addr_lo;
      logic ram_we;
      logic [9:0] ram_addr;
      char_t ram_data;
      marker_st_t mk_st;
      logic [17:0] mk_cnt;
      logic [15:0] gap_cnt;
   } state_t;
endpackage

/* File: hw/crt_readout_ports.sv */
// Instrument-bus ports, character RAM steering and marker dot sequencer.
// Assumes bus pins and line-D are asynchronous; scan counters sit outside.
//
// Behaviour
// [RQ1] Control bit 2 drives RAM address bit nine
// [RQ2] Bit 3 picks max-span dot, else centre
// [RQ3] Control bit 4 drives RAM address bit eight
// [RQ4] Bit 5 selects sixteen-line counter mode
// [RQ5] Bit 6 selects forty characters per line
// [RQ6] Bit 7 high enables 140 us gap timer
// [RQ7] Bit 7 low kills timer, trace, boost, dot
// [RQ8] Host loads character in four ordered writes
// [RQ9] Address-mode write latches low address byte
// [RQ10] Data byte: code, skip, blank flags stored
// [RQ11] Skip flag advances line counter past line
// [RQ12] Blank flag stops scan pulling readout-off low
// [RQ13] Refresh marker after last lower readout position
// [RQ14] Falling line-D starts marker sequence
// [RQ15] Dot interval: deflection, offset, readout-off low
// [RQ16] Wait 5.9 us, then unblank 5 us
// [RQ17] Dot interval held until dot drawn
// [RQ18] Decode nibble 5 and 2 while strobe high
// [RQ19] Latch bus data on falling strobe
// [RQ20] Bit 0 routes scan or load address
// [RQ21] Bit 1 address mode blocks RAM writes
module crt_readout_ports
   import crt_readout_pkg::*;
#(
   parameter int GAP_CYCLES = `GAP_CYC,
   parameter int RETRACE_CYCLES = `RETRACE_CYC,
   parameter int UNBLANK_CYCLES = `UNBLANK_CYC
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic bus_strobe,
   input wire logic [3:0] bus_addr_hi,
   input wire logic [7:0] bus_data,
   input wire logic line_d,
   input wire logic [9:0] scan_addr,
   input wire logic char_done,
   input wire char_t scan_char,
   output logic [9:0] ram_addr,
   output logic ram_we,
   output char_t ram_wdata,
   output logic readout_on,
   output logic lines16_mode,
   output logic col40_mode,
   output logic line_skip,
   output logic gap_timer_en,
   output logic gap_active,
   output logic boost_en,
   output logic char_scan_active,
   output logic readout_off,
   output logic marker_interval_low,
   output logic marker_period_flag,
   output logic marker_draw_pulse,
   output logic hdefl_max_span,
   output logic vdefl_offset
);

   state_t s_r;
   state_t s_nxt;
   logic strobe_fall;
   logic control_port_select;
   logic load_port_select;
   logic lined_fall;
   logic scan_ok;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.ram_we = 1'b0;
      // Bus pins resynchronised; strobe history kept one deeper for edge
      s_nxt.strobe_sync = {s_r.strobe_sync[1:0], bus_strobe};
      // Nibble and data share the strobe's two stages so all three stay aligned
      s_nxt.bus_s1 = {bus_addr_hi, bus_data};
      s_nxt.bus_s2 = s_r.bus_s1;
      s_nxt.lined_sync = {s_r.lined_sync[0], line_d};
      s_nxt.lined_q = s_r.lined_sync[1];
      // [RQ18] Decode while high
      control_port_select = s_r.strobe_sync[1] && s_r.bus_s2[11:8] == `CTRL_NIBBLE;
      load_port_select = s_r.strobe_sync[1] && s_r.bus_s2[11:8] == `LOAD_NIBBLE;
      // Address and data sampled while strobe high; used when it falls
      if (s_r.strobe_sync[1])
      begin
         s_nxt.nib_q = s_r.bus_s2[11:8];
         s_nxt.data_q = s_r.bus_s2[7:0];
      end
      // [RQ19] Latch at strobe fall
      strobe_fall = s_r.strobe_sync[2] && !s_r.strobe_sync[1];
      if (strobe_fall && s_r.nib_q == `CTRL_NIBBLE)
         s_nxt.ctrl = ctrl_t'(s_r.data_q);
      if (strobe_fall && s_r.nib_q == `LOAD_NIBBLE)
      begin
         // [RQ21] Address mode blocks writes
         if (s_r.ctrl.addr_mode)
         begin
            // [RQ9] Low address byte
            s_nxt.addr_lo = s_r.data_q;
            s_nxt.ram_addr = {s_r.ctrl.a9, s_r.ctrl.a8, s_r.data_q};
         end
         else
         begin
            s_nxt.ram_we = 1'b1;
            // [RQ10] Code and flags
            s_nxt.ram_data = char_t'(s_r.data_q);
            // [RQ8] Load address from earlier writes
            // [RQ1] Bit nine from control
            // [RQ3] Bit eight from control
            s_nxt.ram_addr = {s_r.ctrl.a9, s_r.ctrl.a8, s_r.addr_lo};
         end
      end
      // [RQ6] Gap timer between characters
      if (!s_r.ctrl.spectrum_en)
         s_nxt.gap_cnt = '0;
      else if (char_done)
         s_nxt.gap_cnt = 16'(GAP_CYCLES);
      else if (s_r.gap_cnt != '0)
         s_nxt.gap_cnt = s_r.gap_cnt - 16'h0001;
      // [RQ14] Falling line-D trigger
      lined_fall = s_r.lined_q && !s_r.lined_sync[1];
      case (s_r.mk_st)
         MK_IDLE:
         begin
            // [RQ13] Refresh after lower line
            // [RQ7] Dot suppressed when off
            if (lined_fall && s_r.ctrl.spectrum_en)
            begin
               s_nxt.mk_st = MK_RETRACE;
               s_nxt.mk_cnt = 18'(RETRACE_CYCLES - 1);
            end
         end
         MK_RETRACE:
         begin
            // [RQ16] Retrace wait
            if (s_r.mk_cnt == '0)
            begin
               s_nxt.mk_st = MK_DRAW;
               s_nxt.mk_cnt = 18'(UNBLANK_CYCLES - 1);
            end
            else
               s_nxt.mk_cnt = s_r.mk_cnt - 18'h00001;
         end
         MK_DRAW:
         begin
            // [RQ16] Unblank period
            if (s_r.mk_cnt == '0)
               s_nxt.mk_st = MK_IDLE;
            else
               s_nxt.mk_cnt = s_r.mk_cnt - 18'h00001;
         end
         default:
            s_nxt.mk_st = MK_IDLE;
      endcase
   end

   // No documented reset; a defined power-on state is still given here
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_r <= '0;
         s_r.ctrl <= ctrl_t'(`CTRL_RESET);
         s_r.mk_st <= MK_IDLE;
      end
      else
         s_r <= s_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // [RQ20] Scan or load address
   assign ram_addr = s_r.ctrl.readout_on ? scan_addr : s_r.ram_addr;
   assign ram_we = s_r.ram_we;
   assign ram_wdata = s_r.ram_data;
   assign readout_on = s_r.ctrl.readout_on;
   // [RQ4] Sixteen-line mode
   assign lines16_mode = s_r.ctrl.lines16;
   // [RQ5] Forty-column mode
   assign col40_mode = s_r.ctrl.col40;
   // [RQ11] Skip advances line
   assign line_skip = scan_char.skip;
   // [RQ7] Timer and boost off
   assign gap_timer_en = s_r.ctrl.spectrum_en;
   assign boost_en = s_r.ctrl.spectrum_en;
   assign gap_active = s_r.gap_cnt != '0;
   // Scan may run once the gap elapses; blanks are scanned but do not pull readout-off low
   assign scan_ok = s_r.ctrl.readout_on && !gap_active;
   assign char_scan_active = scan_ok;
   // [RQ17] Interval spans retrace and draw
   assign marker_interval_low = !(s_r.mk_st == MK_RETRACE || s_r.mk_st == MK_DRAW);
   assign marker_period_flag = marker_interval_low;
   // [RQ7] Dot never drawn while spectrum bit is low
   assign marker_draw_pulse = s_r.mk_st == MK_DRAW && s_r.ctrl.spectrum_en;
   // [RQ2] Dot horizontal source
   assign hdefl_max_span = !marker_interval_low && s_r.ctrl.max_span;
   // [RQ15] Vertical offset in interval
   assign vdefl_offset = !marker_interval_low;
   // [RQ15] Readout deflection in interval
   // [RQ12] Blank chars skip readout
   // [RQ7] Forced low when off
   assign readout_off = s_r.ctrl.spectrum_en && marker_interval_low
      && !(scan_ok && !scan_char.blank);

endmodule

/* File: tb/rdo_properties.sv */
// Port assertions for the readout ports and the marker dot sequencer.
// Assumes the bench timing: retrace 6 cycles, unblank 5 cycles.
module rdo_properties import crt_readout_pkg::*; (
   input wire logic mclk, rstn, line_d, ram_we, gap_timer_en, boost_en, readout_off,
   input wire logic marker_interval_low, marker_draw_pulse, vdefl_offset, char_scan_active,
   input wire char_t scan_char);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   a_we_single: assert property (ram_we |=> !ram_we) else $error("long write");
   a_off_idle: assert property (!gap_timer_en |-> !readout_off && !marker_draw_pulse)
      else $error("idle leak");
   a_boost_bit: assert property (boost_en == gap_timer_en) else $error("boost");
   a_blank_gate: assert property (char_scan_active && !scan_char.blank |-> !readout_off)
      else $error("scan gate");
   a_dot_deflect: assert property (!marker_interval_low |-> !readout_off && vdefl_offset)
      else $error("deflect");
   a_dot_draw: assert property (marker_draw_pulse |-> !marker_interval_low)
      else $error("draw");
   a_dot_start: assert property ($fell(line_d) && gap_timer_en && marker_interval_low
      |-> ##[2:5] !marker_interval_low) else $error("start");
   a_dot_timing: assert property ($fell(marker_interval_low) |-> (!marker_draw_pulse)[*6]
      ##1 marker_draw_pulse[*5] ##1 (marker_interval_low && !marker_draw_pulse))
      else $error("timing");
   c_write: cover property (ram_we);
   c_draw: cover property ($rose(marker_draw_pulse));
   c_blank: cover property (char_scan_active && scan_char.blank);
endmodule
////////////////////////////////////////
bind crt_readout_ports rdo_properties props_i (.*);

/* File: tb/host_bus.sv */
// Microcomputer bus model: one write cycle to a port.
// Assumes the bench clock; pins change only at falling edges.
module host_bus (
   input wire logic mclk,
   output logic bus_strobe = 1'b0,
   output logic [3:0] bus_addr_hi = 4'h0,
   output logic [7:0] bus_data = 8'h00);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic wr(input logic [3:0] nib, input logic [7:0] d);
      @(negedge mclk);
      bus_addr_hi = nib;
      bus_data = d;
      bus_strobe = 1'b1;
      repeat (3) @(negedge mclk);
      bus_strobe = 1'b0;
      @(negedge mclk);
      bus_data = ~d;
      repeat (5) @(negedge mclk);
   endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the readout ports and marker dot sequencer.
// Assumes short timing parameters; host_bus plays the microcomputer.
module testbench import crt_readout_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rstn = 1'b0, line_d = 1'b1, char_done = 1'b0, bus_strobe, ram_we;
   logic readout_on, lines16_mode, col40_mode, line_skip, gap_timer_en, gap_active, boost_en;
   logic char_scan_active, readout_off, marker_interval_low, marker_period_flag;
   logic marker_draw_pulse, hdefl_max_span, vdefl_offset;
   logic [3:0] bus_addr_hi;
   logic [7:0] bus_data, d, a, c;
   logic [9:0] scan_addr = 10'h000, ram_addr;
   char_t scan_char = 8'h00, ram_wdata;
   int miscompares = 0, compares = 0, seed = 87000;
   logic [17:0] wq[$];
   crt_readout_ports #(.GAP_CYCLES(20), .RETRACE_CYCLES(6), .UNBLANK_CYCLES(5)) uut (.*);
   host_bus hb (.*);
   initial forever #2.5 mclk = ~mclk;
   always @(posedge mclk)
      if (ram_we === 1'b1)
         wq.push_back({ram_addr, ram_wdata});
   task automatic chk(input string nm, input logic [17:0] seen, exp);
      compares++;
      if (seen !== exp)
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      miscompares += int'(seen !== exp);
   endtask
   task automatic stop_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Whole run is near 380 cycles
   initial
   begin
      #20000;
      miscompares++;
      stop_test();
   end
   ////////////////////////////////////////
   initial
   begin
      repeat (2) @(negedge mclk);
      rstn = 1'b1;
      chk("rst", {readout_on, marker_interval_low}, 2'h1);
      repeat (6)
      begin
         {d, a, c} = 24'($random(seed));
         scan_addr = 10'($random(seed));
         scan_char = c;
         wq.delete();
         hb.wr(4'h5, d | 8'h02);
         hb.wr(4'h2, a);
         chk("lvl", {readout_on, lines16_mode, col40_mode, gap_timer_en, line_skip},
            {d[0], d[5], d[6], d[7], c[6]});
         chk("adr", ram_addr, d[0] ? scan_addr : {d[2], d[4], a});
         hb.wr(4'h5, d & 8'hfc);
         hb.wr(4'h7, ~c);
         hb.wr(4'h2, c);
         chk("nwr", 18'(wq.size()), 18'h1);
         chk("wr", wq[0], {d[2], d[4], a, c});
      end
      hb.wr(4'h5, 8'h88);
      line_d = 1'b0;
      repeat (5) @(negedge mclk);
      chk("dot", {readout_off, vdefl_offset, hdefl_max_span, marker_period_flag},
         4'h6);
      line_d = 1'b1;
      repeat (14) @(negedge mclk);
      chk("end", {marker_interval_low, marker_draw_pulse}, 2'h2);
      hb.wr(4'h5, 8'h01);
      line_d = 1'b0;
      repeat (6) @(negedge mclk);
      chk("off", {marker_interval_low, readout_off, boost_en}, 3'h4);
      hb.wr(4'h5, 8'h81);
      scan_char = 8'h80;
      char_done = 1'b1;
      @(negedge mclk);
      char_done = 1'b0;
      chk("gap", {gap_active, char_scan_active}, 2'h2);
      repeat (24) @(negedge mclk);
      chk("blk", {gap_active, char_scan_active, readout_off}, 3'h3);
      stop_test();
   end
endmodule
